// ### hw/vsf_core.sv
// valley select, dimming gate and fault sequencer with ahb-lite registers
`timescale 1ns/1ns
module vsf_core #(
  parameter int AUX_SHORT_CYCLES  = vsf_pkg::AUX_SHORT_CYCLES,
  parameter int LINE_BLANK_CYCLES = vsf_pkg::LINE_BLANK_CYCLES,
  parameter int RECOVERY_CYCLES   = vsf_pkg::RECOVERY_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // analog comparators
  input  wire logic        i_valley_below,
  input  wire logic        i_aux_above_short,
  input  wire logic        i_line_below_low,
  input  wire logic        i_line_above_high,
  input  wire logic        i_setpoint_trip,
  input  wire logic        i_peak_limit_trip,
  input  wire logic        i_overshoot_trip,
  input  wire logic        i_supply_ovp,
  input  wire logic        i_supply_good,
  input  wire logic        i_supply_below_reset,
  input  wire logic        i_thermal_foldback,
  // digitised dimming input, same clock
  input  wire logic [7:0]  i_dimming_input,
  // gate drive and analog controls
  output logic             o_drive_latch,
  output logic             o_feedforward_en,
  output logic [7:0]       o_current_reference,
  output logic             o_valley_clock
);
  // ==========================================================
  // reset release
  logic [1:0] rst_ff;
  logic       rst_n;

  // assert at once, release through two flops
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // ==========================================================
  // comparator synchronisation
  logic valley_low_s, aux_above_s, line_low_s, line_high_s, setpoint_s;
  logic limit_s, ovsh_s, ovp_s, good_s, supply_reset_s, foldback_s;

  vsf_sync #(.WIDTH(11)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_async   ({i_valley_below, i_aux_above_short, i_line_below_low,
                 i_line_above_high, i_setpoint_trip, i_peak_limit_trip,
                 i_overshoot_trip, i_supply_ovp, i_supply_good,
                 i_supply_below_reset, i_thermal_foldback}),
    .o_sync    ({valley_low_s, aux_above_s, line_low_s, line_high_s,
                 setpoint_s, limit_s, ovsh_s, ovp_s, good_s,
                 supply_reset_s, foldback_s})
  );

  // ==========================================================
  // registers and state
  vsf_pkg::fault_state_t fault_state;
  vsf_pkg::fault_state_t next_fault_state;
  logic       latch_variant;
  logic [3:0] foldback_valleys;
  logic       high_line;
  logic       valley_low_d;
  logic       aux_fault, wod_fault, ovp_fault;
  logic [2:0] ovsh_count;
  logic       ovsh_seen;
  logic [3:0] valley_count;
  logic [7:0] on_cnt;
  logic       tmo_done, aux_done, line_done, rec_done;
  logic       valley_edge, running, dim_on, start_pulse, end_pulse;
  logic       ovsh_fault_evt, any_fault, latchable;
  logic [3:0] valleys_needed;
  logic       limit_active, ovsh_active;

  // ==========================================================
  // valley clock
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valley_low_d <= 1'b0;
    end else begin
      valley_low_d <= valley_low_s;
    end
  end
  assign valley_edge = valley_low_s & ~valley_low_d;

  // time-out restarts every interval while sense stays low
  vsf_timer #(.LIMIT(vsf_pkg::TIMEOUT_CYCLES)) u_timeout (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_clear   (~valley_low_s),
    .i_run     (valley_low_s),
    .o_done    (tmo_done)
  );
  assign o_valley_clock = valley_edge | tmo_done;

  // ==========================================================
  // auxiliary short timer, held clear while switching is off
  vsf_timer #(.LIMIT(AUX_SHORT_CYCLES)) u_aux_short (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_clear   (aux_above_s | ~running),
    .i_run     (1'b1),
    .o_done    (aux_done)
  );

  // ==========================================================
  // line range
  vsf_timer #(.LIMIT(LINE_BLANK_CYCLES)) u_line_blank (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_clear   (~line_low_s),
    .i_run     (1'b1),
    .o_done    (line_done)
  );

  // high line at once, low line after blanking
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_line <= 1'b0;
    end else if (line_high_s) begin
      high_line <= 1'b1;
    end else if (line_done) begin
      high_line <= 1'b0;
    end
  end

  // ==========================================================
  // dimming reference
  function automatic logic [7:0] dim_scale(input logic [7:0] code);
    logic [15:0] prod;
    prod = 16'(code - vsf_pkg::DIM_LOW_CODE) * 16'(vsf_pkg::REF_FULL);
    if (code <= vsf_pkg::DIM_LOW_CODE) begin
      dim_scale = 8'h00;
    end else if (code >= vsf_pkg::DIM_FULL_CODE) begin
      dim_scale = vsf_pkg::REF_FULL;
    end else begin
      dim_scale = 8'(prod / 16'(vsf_pkg::DIM_FULL_CODE - vsf_pkg::DIM_LOW_CODE));
    end
  endfunction

  // current reference registered from the dimming code
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_current_reference <= 8'h00;
    end else begin
      o_current_reference <= dim_scale(i_dimming_input);
    end
  end
  assign dim_on = i_dimming_input > vsf_pkg::DIM_LOW_CODE;

  // ==========================================================
  // valley selection
  always_comb begin
    if (foldback_s) begin
      valleys_needed = foldback_valleys;
    end else if (high_line) begin
      valleys_needed = 4'h2;
    end else begin
      valleys_needed = 4'h1;
    end
  end

  // count valley clocks during off-time, saturating
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valley_count <= 4'h0;
    end else if (o_drive_latch) begin
      valley_count <= 4'h0;
    end else if (o_valley_clock && valley_count != 4'hf) begin
      valley_count <= valley_count + 4'h1;
    end
  end

  assign running     = (fault_state == vsf_pkg::ST_RUN);
  assign start_pulse = ~o_drive_latch & running & dim_on & o_valley_clock &
                       ((5'(valley_count) + 5'h01) >= 5'(valleys_needed));
  assign limit_active = on_cnt >= 8'(vsf_pkg::LIMIT_BLANK_CYCLES);
  assign ovsh_active  = on_cnt >= 8'(vsf_pkg::OVSH_BLANK_CYCLES);
  assign end_pulse   = o_drive_latch &
                       (setpoint_s | (limit_s & limit_active) | ~running | ~dim_on);

  // ==========================================================
  // gate drive and on-time counter
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_drive_latch <= 1'b0;
      on_cnt        <= 8'h00;
    end else if (end_pulse) begin
      o_drive_latch <= 1'b0;
      on_cnt        <= 8'h00;
    end else if (start_pulse) begin
      o_drive_latch <= 1'b1;
      on_cnt        <= 8'h00;
    end else if (o_drive_latch && on_cnt != 8'hff) begin
      on_cnt <= on_cnt + 8'h01;
    end
  end
  assign o_feedforward_en = o_drive_latch;

  // ==========================================================
  // overshoot period counter
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovsh_seen  <= 1'b0;
      ovsh_count <= 3'h0;
    end else if (!running) begin
      ovsh_seen  <= 1'b0;
      ovsh_count <= 3'h0;
    end else if (end_pulse) begin
      ovsh_seen  <= 1'b0;
      ovsh_count <= (ovsh_seen | (ovsh_s & ovsh_active)) ? ovsh_count + 3'h1 : 3'h0;
    end else if (o_drive_latch && ovsh_s && ovsh_active) begin
      ovsh_seen <= 1'b1;
    end
  end
  assign ovsh_fault_evt = (ovsh_count == 3'(vsf_pkg::OVERSHOOT_LIMIT));

  // ==========================================================
  // fault sequencer
  assign latchable = aux_done | ovsh_fault_evt;
  assign any_fault = latchable | ovp_s;

  vsf_timer #(.LIMIT(RECOVERY_CYCLES)) u_recovery (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_clear   (fault_state != vsf_pkg::ST_RECOVER),
    .i_run     (1'b1),
    .o_done    (rec_done)
  );

  always_comb begin
    next_fault_state = fault_state;
    unique case (fault_state)
      vsf_pkg::ST_RUN: begin
        if (latchable && latch_variant) begin
          next_fault_state = vsf_pkg::ST_LATCHED;
        end else if (any_fault) begin
          next_fault_state = vsf_pkg::ST_RECOVER;
        end
      end
      vsf_pkg::ST_RECOVER: begin
        if (rec_done) begin
          next_fault_state = vsf_pkg::ST_WAIT;
        end
      end
      vsf_pkg::ST_WAIT: begin
        if (good_s && !ovp_s) begin
          next_fault_state = vsf_pkg::ST_RUN;
        end
      end
      vsf_pkg::ST_LATCHED: begin
        if (supply_reset_s) begin
          next_fault_state = vsf_pkg::ST_RUN;
        end
      end
      default: next_fault_state = vsf_pkg::ST_LATCHED;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_state <= vsf_pkg::ST_RUN;
    end else begin
      fault_state <= next_fault_state;
    end
  end

  // fault causes, cleared on restart, a new event wins
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_fault <= 1'b0;
      wod_fault <= 1'b0;
      ovp_fault <= 1'b0;
    end else begin
      aux_fault <= (aux_fault & ~(next_fault_state == vsf_pkg::ST_RUN)) | aux_done;
      wod_fault <= (wod_fault & ~(next_fault_state == vsf_pkg::ST_RUN)) | ovsh_fault_evt;
      ovp_fault <= (ovp_fault & ~(next_fault_state == vsf_pkg::ST_RUN)) | (ovp_s & running);
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       addr_ok;

  assign addr_ok     = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // address phase capture and read data
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_ok & i_hwrite;
      wr_addr <= i_haddr[7:0];
      if (addr_ok && !i_hwrite && i_haddr[31:8] == 24'h00_0000) begin
        unique case (i_haddr[7:0])
          vsf_pkg::CTRL_ADDR:   o_hrdata <= {24'h00_0000, foldback_valleys, 3'h0, latch_variant};
          vsf_pkg::STATUS_ADDR: o_hrdata <= {23'h00_0000, ovp_fault, wod_fault, aux_fault,
                                             fault_state, o_drive_latch, high_line};
          default:              o_hrdata <= 32'h0000_0000;
        endcase
      end else begin
        o_hrdata <= 32'h0000_0000;
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_variant    <= vsf_pkg::LATCH_VARIANT_RST;
      foldback_valleys <= vsf_pkg::FOLDBACK_VALLEYS_RST;
    end else if (wr_pend && wr_addr == vsf_pkg::CTRL_ADDR) begin
      latch_variant    <= i_hwdata[vsf_pkg::CTRL_LATCH_BIT];
      foldback_valleys <= i_hwdata[vsf_pkg::CTRL_VALLEY_LSB +: 4];
    end
  end

  // ==========================================================
  // checks
  chk_valley_edge_clock: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(valley_low_s) |-> o_valley_clock)
    else $error("valley edge gave no valley clock");
  chk_timeout_only_low: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    tmo_done |-> $past(valley_low_s) && $past(valley_low_s, 2))
    else $error("time-out pulse without low sense");
  chk_off_blocks_drive: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !running |=> !o_drive_latch)
    else $error("drive active in off state");
  chk_dim_blocks_drive: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !dim_on |=> !o_drive_latch)
    else $error("drive active with dimming low");
  chk_limit_ends_pulse: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    o_drive_latch && limit_s && on_cnt >= 8'd3 |=> !o_drive_latch)
    else $error("limit trip did not end pulse");
  chk_feedforward_gate: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(o_drive_latch) |-> o_feedforward_en ##1 (o_feedforward_en == o_drive_latch))
    else $error("feedforward not tied to drive");
  chk_high_line_fast: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    line_high_s |=> high_line)
    else $error("high line not taken at once");
  chk_ovp_recovers: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    running && ovp_s && !latchable |=> fault_state == vsf_pkg::ST_RECOVER)
    else $error("supply overvoltage did not auto-recover");
  chk_wod_latches: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    running && ovsh_count == 3'd4 && latch_variant |=> fault_state == vsf_pkg::ST_LATCHED)
    else $error("fourth overshoot did not latch");
  chk_latch_holds: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    fault_state == vsf_pkg::ST_LATCHED && !supply_reset_s |=> fault_state == vsf_pkg::ST_LATCHED)
    else $error("latched fault released early");
  chk_ref_zero_low: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    i_dimming_input <= vsf_pkg::DIM_LOW_CODE |=> o_current_reference == 8'h00)
    else $error("reference not zero at low dimming");
endmodule // vsf_core

// ### hw/vsf_pkg.sv
// constants for the valley select and fault sequencer
package vsf_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_KHZ            = 10000;
  localparam int TIMEOUT_NS         = 6500;
  localparam int LIMIT_BLANK_NS     = 300;
  localparam int OVERSHOOT_BLANK_NS = 150;
  localparam int AUX_SHORT_MS       = 90;
  localparam int LINE_BLANK_MS      = 25;
  localparam int RECOVERY_MS        = 4000;
  localparam int TIMEOUT_CYCLES     = (TIMEOUT_NS * CLK_KHZ + 999999) / 1000000;
  localparam int LIMIT_BLANK_CYCLES = (LIMIT_BLANK_NS * CLK_KHZ + 999999) / 1000000;
  localparam int OVSH_BLANK_CYCLES  = (OVERSHOOT_BLANK_NS * CLK_KHZ + 999999) / 1000000;
  localparam int AUX_SHORT_CYCLES   = AUX_SHORT_MS * CLK_KHZ;
  localparam int LINE_BLANK_CYCLES  = LINE_BLANK_MS * CLK_KHZ;
  localparam int RECOVERY_CYCLES    = RECOVERY_MS * CLK_KHZ;
  localparam int OVERSHOOT_LIMIT    = 4;

  // ==========================================================
  // dimming scale, digitised dimming input of 8 bits
  localparam int DIM_FS_MV       = 3300;
  localparam int DIM_LOW_MV      = 700;
  localparam int DIM_FULL_MV     = 2450;
  localparam logic [7:0] DIM_LOW_CODE  = 8'(DIM_LOW_MV * 255 / DIM_FS_MV);
  localparam logic [7:0] DIM_FULL_CODE = 8'(DIM_FULL_MV * 255 / DIM_FS_MV);
  localparam logic [7:0] REF_FULL      = 8'hff;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_LATCH_BIT   = 0;
  localparam int CTRL_VALLEY_LSB  = 4;
  localparam logic [3:0] FOLDBACK_VALLEYS_RST = 4'h3;
  localparam logic       LATCH_VARIANT_RST    = 1'b0;

  // ==========================================================
  // fault sequencer states
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_RECOVER = 4'h2,
    ST_WAIT    = 4'h4,
    ST_LATCHED = 4'h8
  } fault_state_t;
endpackage

// ### hw/vsf_sync.sv
// two flip-flop synchroniser for comparator levels
`timescale 1ns/1ns
module vsf_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // vsf_sync

// ### hw/vsf_timer.sv
// interval counter with terminal pulse
`timescale 1ns/1ns
module vsf_timer #(
  parameter int LIMIT = 65
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_clear,
  input  wire logic i_run,
  // terminal pulse
  output logic      o_done
);
  localparam int WIDTH = $clog2(LIMIT + 1);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);
  logic [WIDTH-1:0] cnt;

  // count while running, wrap and pulse at the terminal count
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else if (i_clear) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else if (i_run) begin
      o_done <= (cnt == LAST);
      cnt    <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule // vsf_timer

// ### verification/vsf_partner.sv
// partner model: switch node ringing and current sense behind the gate driver
`timescale 1ns/1ns
module vsf_partner #(
  parameter int HALF   = 10,
  parameter int ON_LEN = 6
) (
  // clock
  input  wire logic i_clk_sys,
  // gate drive and test control
  input  wire logic i_drive,
  input  wire logic i_ring_en,
  // comparator levels
  output logic      o_valley_below    = 1'b1,
  output logic      o_aux_above_short = 1'b0,
  output logic      o_setpoint_trip   = 1'b0
);
  int ring_cnt = 0;
  int on_cnt   = 0;

  // ==========================================================
  // ringing after switch-off; a shorted winding sits below threshold
  always @(posedge i_clk_sys) begin
    ring_cnt          <= i_drive ? 0 : ring_cnt + 1;
    o_valley_below    <= !i_ring_en || i_drive || ((ring_cnt / HALF) % 2 == 1);
    o_aux_above_short <= i_ring_en && !i_drive && ((ring_cnt / HALF) % 2 == 0);
  end

  // sense ramp reaches the setpoint after ON_LEN cycles of on-time
  always @(posedge i_clk_sys) begin
    on_cnt          <= i_drive ? on_cnt + 1 : 0;
    o_setpoint_trip <= i_drive && on_cnt >= ON_LEN;
  end
endmodule // vsf_partner

// ### verification/test_valley_select_fault_sequencer.sv
// self-checking bench for the valley select and fault sequencer
`timescale 1ns/1ns
module test_valley_select_fault_sequencer;
  localparam int HALF = 10;
  localparam int LB   = 100;
  localparam int RC   = 300;
  logic        i_clk_sys = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata, rd_q;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_line_below_low = 1'b0, i_line_above_high = 1'b0, i_peak_limit_trip = 1'b0;
  logic        i_overshoot_trip = 1'b0, i_supply_ovp = 1'b0, i_supply_below_reset = 1'b0;
  logic        i_supply_good = 1'b1, i_thermal_foldback = 1'b0, ring_en = 1'b1;
  logic [7:0]  i_dimming_input = 8'hff, o_current_reference;
  logic        o_hreadyout, o_hresp, rdy_q, o_drive_latch, o_feedforward_en, o_valley_clock;
  logic        vbelow, aabove, sp_trip;
  int          n_mismatch = 0, samples_checked = 0;

  vsf_core #(.AUX_SHORT_CYCLES(200), .LINE_BLANK_CYCLES(LB), .RECOVERY_CYCLES(RC)) u_dut (
    .i_clk_sys, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_valley_below(vbelow),
    .i_aux_above_short(aabove), .i_line_below_low, .i_line_above_high,
    .i_setpoint_trip(sp_trip), .i_peak_limit_trip, .i_overshoot_trip, .i_supply_ovp,
    .i_supply_good, .i_supply_below_reset, .i_thermal_foldback, .i_dimming_input,
    .o_drive_latch, .o_feedforward_en, .o_current_reference, .o_valley_clock);
  vsf_partner #(.HALF(HALF)) u_partner (.i_clk_sys, .i_drive(o_drive_latch),
    .i_ring_en(ring_en), .o_valley_below(vbelow), .o_aux_above_short(aabove),
    .o_setpoint_trip(sp_trip));

  // ==========================================================
  // clock, and bus values as they stood at each edge
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    rd_q  <= o_hrdata;
    rdy_q <= o_hreadyout;
  end

  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v) begin
      tick(1);
      n++;
      if (n > lim) begin
        check_range("wait bound", 0, lim, n);
        end_of_test();
      end
    end
  endtask
  // one single word transfer; hready taken from the edge values
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= wr;
    tick(1);
    wait_lvl(rdy_q, 1'b1, 20, n);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    tick(1);
    wait_lvl(rdy_q, 1'b1, 20, n);
    rd = rd_q;
  endtask
  task automatic status(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, vsf_pkg::STATUS_ADDR, '0, r);
    check("status", exp, r & mask);
  endtask
  task automatic wait_state(input logic [31:0] st, input int lim, output int n);
    logic [31:0] r;
    time t0;
    t0 = $time;
    do begin
      ahb(1'b0, vsf_pkg::STATUS_ADDR, '0, r);
    end while ((r & 32'h3c) !== st && $time - t0 < lim * 100);
    n = int'(($time - t0) / 100);
    check("fault state", st, r & 32'h3c);
  endtask
  // off time from the end of a whole pulse to the next gate pulse
  task automatic gap(input int lo, input int hi);
    int n;
    wait_lvl(o_drive_latch, 1'b1, 300, n);
    wait_lvl(o_drive_latch, 1'b0, 300, n);
    check("feedforward off", 32'h0, {31'h0, o_feedforward_en});
    wait_lvl(o_drive_latch, 1'b1, 300, n);
    check("feedforward on", 32'h1, {31'h0, o_feedforward_en});
    check_range("off time", lo, hi, n);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    ahb(1'b0, vsf_pkg::CTRL_ADDR, '0, r);
    check("ctrl reset", 32'h30, r);
    check("response", 32'h0, {31'h0, o_hresp});
    status(32'h3d, 32'h04);
    ahb(1'b1, vsf_pkg::CTRL_ADDR, 32'h51, r);
    ahb(1'b0, vsf_pkg::CTRL_ADDR, '0, r);
    check("ctrl rw", 32'h51, r);
    ahb(1'b1, 8'h08, 32'hff, r);
    ahb(1'b0, 8'h08, '0, r);
    check("unmapped", 32'h0, r);
    ahb(1'b1, vsf_pkg::CTRL_ADDR, 32'h30, r);
    $display("test regs done");
  endtask
  task automatic t_valleys();
    gap(HALF, 2 * HALF);
    i_line_above_high <= 1'b1;
    tick(4);
    status(32'h1, 32'h1);
    gap(3 * HALF, 4 * HALF);
    i_thermal_foldback <= 1'b1;
    tick(4);
    gap(5 * HALF, 6 * HALF);
    i_thermal_foldback <= 1'b0;
    i_line_above_high  <= 1'b0;
    i_line_below_low   <= 1'b1;
    tick(LB / 2);
    status(32'h1, 32'h1);
    tick(LB);
    status(32'h1, 32'h0);
    gap(HALF, 2 * HALF);
    $display("test valleys done");
  endtask
  task automatic t_dim();
    int n;
    i_dimming_input <= 8'h79;
    tick(3);
    check("reference", 32'h7e, {24'h0, o_current_reference});
    i_dimming_input <= vsf_pkg::DIM_LOW_CODE;
    tick(3);
    check("reference", 32'h0, {24'h0, o_current_reference});
    n = 0;
    repeat (100) begin
      tick(1);
      n += int'(o_drive_latch);
    end
    check_range("dim off pulses", 0, 0, n);
    i_dimming_input <= vsf_pkg::DIM_FULL_CODE;
    tick(3);
    check("reference", {24'h0, vsf_pkg::REF_FULL}, {24'h0, o_current_reference});
    gap(HALF, 4 * HALF);
    i_dimming_input <= 8'hff;
    $display("test dim done");
  endtask
  task automatic t_limit();
    int n;
    i_peak_limit_trip <= 1'b1;
    wait_lvl(o_drive_latch, 1'b0, 300, n);
    wait_lvl(o_drive_latch, 1'b1, 300, n);
    wait_lvl(o_drive_latch, 1'b0, 300, n);
    check_range("limited on time", vsf_pkg::LIMIT_BLANK_CYCLES,
                vsf_pkg::LIMIT_BLANK_CYCLES + 2, n);
    i_peak_limit_trip <= 1'b0;
    $display("test limit done");
  endtask
  task automatic t_aux_short();
    int n;
    ring_en <= 1'b0;
    wait_lvl(o_valley_clock, 1'b1, 100, n);
    tick(1);
    wait_lvl(o_valley_clock, 1'b1, 100, n);
    check_range("timeout period", vsf_pkg::TIMEOUT_CYCLES - 1, vsf_pkg::TIMEOUT_CYCLES + 1,
                n + 1);
    wait_state(32'h08, 300, n);
    status(32'h40, 32'h40);
    ring_en <= 1'b1;
    wait_state(32'h04, RC + 100, n);
    check_range("recovery hold", RC - 20, RC + 20, n);
    $display("test aux short done");
  endtask
  task automatic t_overshoot_latch();
    int n;
    logic [31:0] r;
    ahb(1'b1, vsf_pkg::CTRL_ADDR, 32'h31, r);
    i_overshoot_trip <= 1'b1;
    wait_state(32'h20, 300, n);
    i_overshoot_trip <= 1'b0;
    status(32'h80, 32'h80);
    tick(RC + 50);
    status(32'h3e, 32'h20);
    i_supply_below_reset <= 1'b1;
    tick(4);
    i_supply_below_reset <= 1'b0;
    wait_state(32'h04, 20, n);
    $display("test overshoot latch done");
  endtask
  task automatic t_overvoltage();
    int n;
    i_supply_ovp  <= 1'b1;
    i_supply_good <= 1'b0;
    wait_state(32'h08, 20, n);
    status(32'h100, 32'h100);
    i_supply_ovp <= 1'b0;
    tick(RC + 20);
    status(32'h3e, 32'h10);
    i_supply_good <= 1'b1;
    wait_state(32'h04, 20, n);
    gap(HALF, 4 * HALF);
    $display("test overvoltage done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    tick(4);
    i_resetn <= 1'b1;
    tick(6);
    t_regs();
    t_valleys();
    t_dim();
    t_limit();
    t_aux_short();
    t_overshoot_latch();
    t_overvoltage();
    end_of_test();
  end
endmodule // test_valley_select_fault_sequencer
